/* File: hdl/sird_decoder.sv */
// decoder for script i/o and register read/write instructions
`timescale 1ns/1ns
module sird_decoder
  import sird_pkg::*;
#(
  parameter int ADDR_WIDTH = 32,
  parameter int REG_SEL_WIDTH = 7
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // instruction from the fetch path
  input wire logic instrValid,
  input wire logic [31:0] instrWord0,
  input wire logic [31:0] instrWord1,
  input wire logic [ADDR_WIDTH-1:0] scriptPointer,
  input wire logic [ADDR_WIDTH-1:0] dataStructureBase,
  // configuration from the test register
  input wire logic loopbackEnable,
  // decoded i/o fields for the phase engine
  output logic isIoInstr,
  output logic isRwInstr,
  output logic [2:0] ioOpcode,
  output sird_addr_mode_e addrMode,
  output logic [2:0] destScsiId,
  output logic idFromTable,
  output logic [ADDR_WIDTH-1:0] tableFetchAddr,
  output logic [ADDR_WIDTH-1:0] failJumpAddr,
  output logic selectWithAttention,
  output logic illegalInstr,
  // register file access
  output logic [REG_SEL_WIDTH-1:0] regSelect,
  input wire logic [7:0] regReadData,
  output logic regWriteEn,
  output logic [7:0] regWriteData,
  // control state
  output logic aluCarry,
  output logic [7:0] scsiControlRegZero,
  output logic [7:0] firstByteReceivedReg,
  output logic ackLatch,
  output logic atnLatch,
  // scsi control lines, high means asserted
  output logic acknowledgeOutLine,
  output logic acknowledgeOutEn,
  output logic attentionOutLine,
  output logic attentionOutEn
);

  logic [1:0] instrType;
  logic [2:0] opcode;
  logic [2:0] aluOp;
  logic relBit;
  logic tableBit;
  logic [ADDR_WIDTH-1:0] tableOfs;
  logic [ADDR_WIDTH-1:0] jumpOfs;
  logic doSet;
  logic doClear;
  logic rwFire;
  logic toFirst;
  logic [7:0] srcByte;
  logic [7:0] aluResult;
  logic aluCarryOut;
  logic aluCarryValid;
  logic carry_reg;
  logic carry_next;
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl0_next;
  logic [7:0] firstByte_reg;
  logic [7:0] firstByte_next;
  logic ack_reg;
  logic ack_next;
  logic atn_reg;
  logic atn_next;
  logic initiatorRole;
  logic busDriveOk;

  // field extraction, all combinational so results stand this cycle
  assign instrType = instrWord0[TYPE_HI:TYPE_LO];
  assign opcode = instrWord0[OPC_HI:OPC_LO];
  assign aluOp = instrWord0[OPR_HI:OPR_LO];
  assign relBit = instrWord0[BIT_RELATIVE];
  assign tableBit = instrWord0[BIT_TABLE];

  assign isIoInstr = instrValid && (instrType == TYPE_IO_RW)
                     && (opcode <= OPC_LAST_IO);
  assign isRwInstr = instrValid && (instrType == TYPE_IO_RW)
                     && (opcode > OPC_LAST_IO);
  assign ioOpcode = opcode;

  always_comb begin
    if (relBit && tableBit) begin
      addrMode = SIRD_TABLE_RELATIVE;
    end else if (relBit) begin
      addrMode = SIRD_RELATIVE;
    end else if (tableBit) begin
      addrMode = SIRD_TABLE_INDIRECT;
    end else begin
      addrMode = SIRD_DIRECT;
    end
  end

  // id comes from the instruction unless a table mode fetches it
  assign destScsiId = instrWord0[DEST_ID_HI:DEST_ID_LO];
  assign idFromTable = tableBit;

  // offsets are signed, so the structure may sit below the base
  assign tableOfs = {{(ADDR_WIDTH-OFS_WIDTH){instrWord0[TABLE_OFS_HI]}},
                     instrWord0[TABLE_OFS_HI:0]};
  assign tableFetchAddr = dataStructureBase + tableOfs;

  assign jumpOfs = {{(ADDR_WIDTH-OFS_WIDTH){instrWord1[JUMP_OFS_HI]}},
                    instrWord1[JUMP_OFS_HI:0]};
  // absolute in direct and table indirect modes
  assign failJumpAddr = relBit ? scriptPointer + jumpOfs
                               : instrWord1[ADDR_WIDTH-1:0];

  assign selectWithAttention = isIoInstr && (opcode == OPC_SELECT)
                               && instrWord0[BIT_SEL_ATN];
  assign illegalInstr = isIoInstr && (opcode != OPC_SELECT)
                        && instrWord0[BIT_SEL_ATN];

  // read/write path
  assign regSelect = instrWord0[REG_SEL_HI:REG_SEL_LO];
  assign toFirst = (opcode == OPC_TO_FIRST);
  // op code 101 reads the first byte register, others the selected one
  assign srcByte = (opcode == OPC_FROM_FIRST) ? firstByte_reg
                                              : regReadData;

  sird_alu #(
    .WIDTH(8)
  ) u_alu (
    .aluOp(aluOp),
    .srcByte(srcByte),
    .immByte(instrWord0[IMM_HI:IMM_LO]),
    .carryIn(carry_reg),
    .result(aluResult),
    .carryOut(aluCarryOut),
    .carryValid(aluCarryValid)
  );

  assign rwFire = clkEn && isRwInstr;
  assign regWriteEn = rwFire && !toFirst;
  assign regWriteData = aluResult;

  // set and clear control
  assign doSet = clkEn && isIoInstr && (opcode == OPC_SET);
  assign doClear = clkEn && isIoInstr && (opcode == OPC_CLEAR);

  always_comb begin
    carry_next = carry_reg;
    if (doSet && instrWord0[BIT_CARRY]) begin
      carry_next = 1'b1;
    end else if (doClear && instrWord0[BIT_CARRY]) begin
      carry_next = 1'b0;
    end else if (rwFire && aluCarryValid) begin
      carry_next = aluCarryOut;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      carry_reg <= 1'b0;
    end else if (clkEn) begin
      carry_reg <= carry_next;
    end
  end

  always_comb begin
    ctrl0_next = ctrl0_reg;
    if (doSet && instrWord0[BIT_TARGET]) begin
      ctrl0_next[CTRL0_TARGET_BIT] = 1'b1;
    end else if (doClear && instrWord0[BIT_TARGET]) begin
      ctrl0_next[CTRL0_TARGET_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl0_reg <= CTRL0_RESET;
    end else if (clkEn) begin
      ctrl0_reg <= ctrl0_next;
    end
  end

  always_comb begin
    ack_next = ack_reg;
    atn_next = atn_reg;
    if (doSet) begin
      ack_next = ack_reg | instrWord0[BIT_ACK];
      atn_next = atn_reg | instrWord0[BIT_ATN];
    end else if (doClear) begin
      ack_next = ack_reg & ~instrWord0[BIT_ACK];
      atn_next = atn_reg & ~instrWord0[BIT_ATN];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      atn_reg <= 1'b0;
    end else if (clkEn) begin
      ack_reg <= ack_next;
      atn_reg <= atn_next;
    end
  end

  always_comb begin
    firstByte_next = firstByte_reg;
    if (rwFire && toFirst) begin
      firstByte_next = aluResult;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      firstByte_reg <= FIRST_BYTE_RESET;
    end else if (clkEn) begin
      firstByte_reg <= firstByte_next;
    end
  end

  // latches keep their value in target role; only the pins are gated
  assign initiatorRole = !ctrl0_reg[CTRL0_TARGET_BIT];
  assign busDriveOk = initiatorRole || loopbackEnable;
  assign acknowledgeOutLine = ack_reg && busDriveOk;
  assign acknowledgeOutEn = acknowledgeOutLine;
  // atn before clearing ack relies on the script keeping that order
  assign attentionOutLine = atn_reg && busDriveOk;
  assign attentionOutEn = attentionOutLine;

  assign aluCarry = carry_reg;
  assign scsiControlRegZero = ctrl0_reg;
  assign firstByteReceivedReg = firstByte_reg;
  assign ackLatch = ack_reg;
  assign atnLatch = atn_reg;

endmodule

/* File: hdl/sird_pkg.sv */
// shared constants for the script i/o and read/write instruction decoder
package sird_pkg;

  // instruction type field
  localparam int TYPE_HI = 31;
  localparam int TYPE_LO = 30;
  localparam logic [1:0] TYPE_IO_RW = 2'h1;

  // op code field
  localparam int OPC_HI = 29;
  localparam int OPC_LO = 27;
  localparam logic [2:0] OPC_SELECT = 3'h0;
  localparam logic [2:0] OPC_WAIT_DISC = 3'h1;
  localparam logic [2:0] OPC_WAIT_RESEL = 3'h2;
  localparam logic [2:0] OPC_SET = 3'h3;
  localparam logic [2:0] OPC_CLEAR = 3'h4;
  localparam logic [2:0] OPC_LAST_IO = 3'h4;
  localparam logic [2:0] OPC_FROM_FIRST = 3'h5;
  localparam logic [2:0] OPC_TO_FIRST = 3'h6;
  localparam logic [2:0] OPC_RMW = 3'h7;

  // operator field and alu operators
  localparam int OPR_HI = 26;
  localparam int OPR_LO = 24;
  localparam logic [2:0] ALU_MOVE = 3'h0;
  localparam logic [2:0] ALU_SHL = 3'h1;
  localparam logic [2:0] ALU_OR = 3'h2;
  localparam logic [2:0] ALU_XOR = 3'h3;
  localparam logic [2:0] ALU_AND = 3'h4;
  localparam logic [2:0] ALU_SHR = 3'h5;
  localparam logic [2:0] ALU_ADD = 3'h6;
  localparam logic [2:0] ALU_ADDC = 3'h7;

  // i/o instruction bit positions
  localparam int BIT_RELATIVE = 26;
  localparam int BIT_TABLE = 25;
  localparam int BIT_SEL_ATN = 24;
  localparam int DEST_ID_HI = 18;
  localparam int DEST_ID_LO = 16;
  localparam int BIT_CARRY = 10;
  localparam int BIT_TARGET = 9;
  localparam int BIT_ACK = 6;
  localparam int BIT_ATN = 3;
  localparam int TABLE_OFS_HI = 23;
  localparam int JUMP_OFS_HI = 23;
  localparam int OFS_WIDTH = 24;

  // read/write instruction fields
  localparam int REG_SEL_HI = 22;
  localparam int REG_SEL_LO = 16;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 8;

  // control bit positions and reset values
  localparam int CTRL0_TARGET_BIT = 0;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] FIRST_BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    SIRD_DIRECT,
    SIRD_TABLE_INDIRECT,
    SIRD_RELATIVE,
    SIRD_TABLE_RELATIVE
  } sird_addr_mode_e;

endpackage

/* File: hdl/sird_alu.sv */
// byte alu for read/write instructions
`timescale 1ns/1ns
module sird_alu
  import sird_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // operation select
  input wire logic [2:0] aluOp,
  // operands
  input wire logic [WIDTH-1:0] srcByte,
  input wire logic [WIDTH-1:0] immByte,
  input wire logic carryIn,
  // result
  output logic [WIDTH-1:0] result,
  output logic carryOut,
  output logic carryValid
);

  logic [WIDTH:0] sum;

  always_comb begin
    sum = '0;
    result = srcByte;
    carryOut = 1'b0;
    carryValid = 1'b0;
    case (aluOp)
      ALU_MOVE: result = immByte;
      ALU_SHL: result = {srcByte[WIDTH-2:0], 1'b0};
      ALU_OR: result = srcByte | immByte;
      ALU_XOR: result = srcByte ^ immByte;
      ALU_AND: result = srcByte & immByte;
      ALU_SHR: result = {1'b0, srcByte[WIDTH-1:1]};
      ALU_ADD: begin
        sum = {1'b0, srcByte} + {1'b0, immByte};
        result = sum[WIDTH-1:0];
        carryOut = sum[WIDTH];
        carryValid = 1'b1;
      end
      default: begin
        // add with carry folds the alu carry into bit 0
        sum = {1'b0, srcByte} + {1'b0, immByte}
            + {{WIDTH{1'b0}}, carryIn};
        result = sum[WIDTH-1:0];
        carryOut = sum[WIDTH];
        carryValid = 1'b1;
      end
    endcase
  end

endmodule

/* File: testbench/sird_decoder_sva.sv */
// concurrent checks on the decoder top ports
`timescale 1ns/1ns
module sird_decoder_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched inputs
  input wire logic clkEn,
  input wire logic instrValid,
  input wire logic [31:0] instrWord0,
  input wire logic loopbackEnable,
  // watched outputs
  input wire logic isIoInstr,
  input wire logic isRwInstr,
  input wire logic selectWithAttention,
  input wire logic illegalInstr,
  input wire logic regWriteEn,
  input wire logic aluCarry,
  input wire logic [7:0] scsiControlRegZero,
  input wire logic ackLatch,
  input wire logic acknowledgeOutLine
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire [2:0] opc = instrWord0[29:27];
  wire ioGo = clkEn && isIoInstr;
  property p_sel;
    isIoInstr |-> selectWithAttention == (opc == 3'h0 && instrWord0[24]);
  endproperty
  a_sel: assert property (p_sel) else $error("select attention bad");
  property p_ill;
    isIoInstr |-> illegalInstr == (opc != 3'h0 && instrWord0[24]);
  endproperty
  a_ill: assert property (p_ill) else $error("illegal flag bad");
  property p_cls;
    instrValid && instrWord0[31:30] == 2'h1 |-> isIoInstr == (opc <= 3'h4)
      && isRwInstr == (opc > 3'h4);
  endproperty
  a_cls: assert property (p_cls) else $error("class bad");
  property p_cry;
    ioGo && opc == 3'h3 && instrWord0[10] |=> aluCarry;
  endproperty
  a_cry: assert property (p_cry) else $error("carry not set");
  property p_tgt;
    ioGo && opc == 3'h4 && instrWord0[9] |=> !scsiControlRegZero[0];
  endproperty
  a_tgt: assert property (p_tgt) else $error("target not cleared");
  property p_ack;
    ioGo && opc == 3'h3 && instrWord0[6] |=> ackLatch;
  endproperty
  a_ack: assert property (p_ack) else $error("ack latch not set");
  property p_pin;
    acknowledgeOutLine
      == (ackLatch && (!scsiControlRegZero[0] || loopbackEnable));
  endproperty
  a_pin: assert property (p_pin) else $error("ack pin gating bad");
  property p_wr;
    clkEn && isRwInstr |-> regWriteEn == (opc != 3'h6);
  endproperty
  a_wr: assert property (p_wr) else $error("write enable bad");
endmodule
bind sird_decoder sird_decoder_sva chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .clkEn(clkEn), .instrValid(instrValid), .instrWord0(instrWord0),
  .loopbackEnable(loopbackEnable), .isIoInstr(isIoInstr),
  .isRwInstr(isRwInstr), .selectWithAttention(selectWithAttention),
  .illegalInstr(illegalInstr), .regWriteEn(regWriteEn), .aluCarry(aluCarry),
  .scsiControlRegZero(scsiControlRegZero), .ackLatch(ackLatch),
  .acknowledgeOutLine(acknowledgeOutLine));

/* File: testbench/sird_regfile_model.sv */
// register file model behind the decoder register port
`timescale 1ns/1ns
module sird_regfile_model (
  // clock
  input wire logic core_clk,
  // access from the decoder
  input wire logic [6:0] regSelect,
  input wire logic regWriteEn,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData
);
  logic [7:0] mem [128];
  // read is combinational, rmw needs the byte in the same cycle
  assign regReadData = mem[regSelect];
  always_ff @(posedge core_clk) begin
    if (regWriteEn) begin
      mem[regSelect] <= regWriteData;
    end
  end
endmodule

/* File: testbench/sird_decoder_tb.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/1ns
module sird_decoder_tb;
  logic core_clk, rst_n, instrValid, loopbackEnable, clkEn, ackEn, atnEn;
  logic [1:0] addrMode;
  logic [31:0] instrWord0, instrWord1, scriptPointer, dataStructureBase;
  logic isIoInstr, isRwInstr, idFromTable, selectWithAttention, illegalInstr;
  logic regWriteEn, aluCarry, ackLatch, atnLatch, ackOut, atnOut;
  logic [2:0] destScsiId;
  logic [31:0] tableFetchAddr, failJumpAddr;
  logic [6:0] regSelect;
  logic [7:0] regReadData, regWriteData, ctrlZero, firstByte;
  logic [7:0] exp8 [8] = '{8'hc5, 8'h2c, 8'hd7, 8'h53, 8'h84, 8'h4b,
    8'h5b, 8'h5c};
  int failCount, checks, cycles;
  sird_decoder dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .instrValid(instrValid), .instrWord0(instrWord0),
    .instrWord1(instrWord1), .scriptPointer(scriptPointer),
    .dataStructureBase(dataStructureBase), .loopbackEnable(loopbackEnable),
    .isIoInstr(isIoInstr), .isRwInstr(isRwInstr), .ioOpcode(),
    .addrMode(addrMode),
    .destScsiId(destScsiId), .idFromTable(idFromTable),
    .tableFetchAddr(tableFetchAddr), .failJumpAddr(failJumpAddr),
    .selectWithAttention(selectWithAttention), .illegalInstr(illegalInstr),
    .regSelect(regSelect), .regReadData(regReadData),
    .regWriteEn(regWriteEn), .regWriteData(regWriteData),
    .aluCarry(aluCarry), .scsiControlRegZero(ctrlZero),
    .firstByteReceivedReg(firstByte), .ackLatch(ackLatch),
    .atnLatch(atnLatch), .acknowledgeOutLine(ackOut),
    .acknowledgeOutEn(ackEn), .attentionOutLine(atnOut),
    .attentionOutEn(atnEn));
  sird_regfile_model model_u (.core_clk(core_clk), .regSelect(regSelect),
    .regWriteEn(regWriteEn), .regWriteData(regWriteData),
    .regReadData(regReadData));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // words change at the falling edge, outputs sampled 1 ns later
  task automatic ex(input logic [31:0] w0, input logic [31:0] w1);
    @(negedge core_clk);
    instrWord0 = w0;
    instrWord1 = w1;
    instrValid = 1'b1;
    #1;
  endtask
  task automatic idle;
    @(negedge core_clk);
    instrValid = 1'b0;
    #1;
  endtask
  function automatic logic [31:0] io(input logic [2:0] o,
    input logic [26:0] b);
    return {2'h1, o, b};
  endfunction
  // register 12h is the rmw target throughout
  function automatic logic [31:0] rw(input logic [2:0] o,
    input logic [2:0] op, input logic [7:0] d);
    return {2'h1, o, op, 1'b0, 7'h12, d, 8'h00};
  endfunction
  task automatic finishTest;
    $display("checks=%0d mismatches=%0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      failCount++;
      finishTest();
    end
  end
  initial begin
    rst_n = 1'b0;
    instrValid = 1'b0;
    loopbackEnable = 1'b0;
    clkEn = 1'b1;
    instrWord0 = 32'h0;
    instrWord1 = 32'h0;
    scriptPointer = 32'h1000;
    dataStructureBase = 32'h1000_0000;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    // set carry, target, ack, atn: target role hides the pins
    ex(io(3'h3, 27'h648), 32'h0);
    idle();
    chk({aluCarry, ctrlZero[0]}, 2'h3);
    chk({ackLatch, atnLatch, ackOut, atnOut}, 4'hc);
    chk({ackEn, atnEn}, 2'h0);
    loopbackEnable = 1'b1;
    #1;
    chk(ackOut, 1'h1);
    loopbackEnable = 1'b0;
    // reject sequence: attention first, then ack drop plus clears
    ex(io(3'h3, 27'h8), 32'h0);
    ex(io(3'h4, 27'h640), 32'h0);
    idle();
    chk({ackLatch, atnLatch, aluCarry, ctrlZero[0]}, 4'h4);
    chk({atnOut, atnEn}, 2'h3);
    ex(io(3'h0, 27'h5050000), 32'h00ff_fff0);
    chk({selectWithAttention, illegalInstr, destScsiId}, 5'h15);
    chk({idFromTable, addrMode}, 3'h2);
    chk(failJumpAddr, 32'h0000_0ff0);
    ex(io(3'h1, 27'h1000000), 32'hdead_beef);
    chk(illegalInstr, 1'h1);
    chk(failJumpAddr, 32'hdead_beef);
    ex(io(3'h2, 27'h6800004), 32'h0);
    chk({idFromTable, addrMode}, 3'h7);
    chk(tableFetchAddr, 32'h0f80_0004);
    for (int i = 0; i < 8; i++) begin
      ex(io(i[2:0], 27'h0), 32'h0);
      chk({isIoInstr, isRwInstr}, i < 5 ? 2'h2 : 2'h1);
    end
    ex(32'hf800_0000, 32'h0);
    chk({isIoInstr, isRwInstr, regWriteEn}, 3'h0);
    // reload the register before each operator so every result is known
    for (int op = 0; op < 8; op++) begin
      ex(rw(3'h7, 3'h0, 8'h96), 32'h0);
      ex(rw(3'h7, op[2:0], 8'hc5), 32'h0);
      chk({regWriteEn, regWriteData}, {1'h1, exp8[op]});
    end
    idle();
    chk({aluCarry, regSelect, regReadData}, 16'h925c);
    ex(rw(3'h6, 3'h2, 8'h0f), 32'h0);
    chk(regWriteEn, 1'h0);
    idle();
    chk(firstByte, 8'h5f);
    ex(rw(3'h5, 3'h1, 8'h00), 32'h0);
    chk({regWriteEn, regWriteData}, 9'h1be);
    // enable low: no write strobe and no state change
    clkEn = 1'b0;
    ex(io(3'h3, 27'h200), 32'h0);
    idle();
    chk(ctrlZero[0], 1'h0);
    ex(rw(3'h7, 3'h0, 8'h11), 32'h0);
    chk(regWriteEn, 1'h0);
    clkEn = 1'b1;
    idle();
    finishTest();
  end
endmodule
